// >>> core/ouas_top.sv
// Alarm/status logic of a multi-channel analogue output unit: lamps, status word, drive modes.
// Assumes host-side fault inputs and configuration on clock_i; switch pins are asynchronous.
`timescale 1ns/10ps
module ouas_top #(
  parameter int NUM_CH         = 8,
  parameter int FLASH_HALF_CYC = ouas_pkg::FLASH_HALF_CYC,
  parameter int RESTART_CYC    = ouas_pkg::RESTART_CYC
) (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic [6:0]           unit_no_i,
  input  wire logic                 cal_sw_i,
  input  wire ouas_pkg::ouas_host_t host_i,
  input  wire ouas_pkg::ouas_cfg_t  cfg_i,
  input  wire logic                 restart_i,
  input  wire logic                 nv_fail_i,
  input  wire logic                 bus_wr_i,
  input  wire logic                 bus_rd_i,
  input  wire logic [15:0]          bus_addr_i,
  input  wire logic [15:0]          bus_wdata_i,
  output logic [15:0]               bus_rdata_o,
  output logic                      bus_rvalid_o,
  output ouas_pkg::ouas_outs_t      chan_out_o,
  output logic                      run_lamp_o,
  output logic                      unit_alarm_lamp_o,
  output logic                      host_fault_lamp_o,
  output logic                      calibration_lamp_o
);
  import ouas_pkg::*;

  // Pin synchronisers: three stages, value taken once stages two and three agree
  logic [6:0]  unit_s1, unit_s2, unit_s3, unit_q;
  logic        cal_s1, cal_s2, cal_s3, cal_q;
  logic [6:0]  next_unit_q;
  logic        next_cal_q;

  always_comb begin
    next_unit_q = (unit_s2 == unit_s3) ? unit_s3 : unit_q;
    next_cal_q  = (cal_s2 == cal_s3) ? cal_s3 : cal_q;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      unit_s1 <= 7'h00;
      unit_s2 <= 7'h00;
      unit_s3 <= 7'h00;
      unit_q  <= 7'h00;
      cal_s1  <= 1'b0;
      cal_s2  <= 1'b0;
      cal_s3  <= 1'b0;
      cal_q   <= 1'b0;
    end else begin
      unit_s1 <= unit_no_i;
      unit_s2 <= unit_s1;
      unit_s3 <= unit_s2;
      unit_q  <= next_unit_q;
      cal_s1  <= cal_sw_i;
      cal_s2  <= cal_s1;
      cal_s3  <= cal_s2;
      cal_q   <= next_cal_q;
    end
  end

  // Shared I/O area decode
  logic [15:0] base;
  logic [15:0] ofs;
  logic        unit_bad;
  logic [IO_WORDS-1:0][15:0] io_words, next_io_words;

  always_comb begin
    base     = 16'(IO_BASE + 16'(16'(unit_q) * IO_STRIDE));
    ofs      = 16'(bus_addr_i - base);
    unit_bad = (unit_q > UNIT_MAX) || host_i.unit_dup;
  end

  always_comb begin
    next_io_words = io_words;
    if (bus_wr_i && (ofs < 16'(IO_WORDS)))
      next_io_words[ofs[3:0]] = bus_wdata_i;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i)
      io_words <= '{default: WORD_RST};
    else
      io_words <= next_io_words;
  end

  // Calibration-mode view of the words
  logic [7:0]  cal_sel;
  logic [7:0]  cal_idx;
  logic        commit;
  logic        chsel_err;
  logic        host_mode_err;

  always_comb begin
    cal_sel       = io_words[OFS_CTRL[3:0]][7:0];
    cal_idx       = 8'(cal_sel - CAL_SEL_LO);
    commit        = io_words[OFS_CAL_CTRL[3:0]][B_COMMIT];
    chsel_err     = cal_q && ((cal_sel < CAL_SEL_LO) || (cal_sel > CAL_SEL_HI) ||
                    (cal_idx >= 8'(NUM_CH)) || !cfg_i.ch_en[cal_idx[2:0]]);
    host_mode_err = cal_q && host_i.host_run_mode;
  end

  // Setup checks
  logic scale_bad, hold_bad, mode_bad;

  always_comb begin
    scale_bad = cfg_i.scale_en &&
                (($signed(cfg_i.scale_lo) < $signed(SCALE_MIN)) ||
                 ($signed(cfg_i.scale_lo) > $signed(SCALE_MAX)) ||
                 ($signed(cfg_i.scale_hi) < $signed(SCALE_MIN)) ||
                 ($signed(cfg_i.scale_hi) > $signed(SCALE_MAX)) ||
                 ((cfg_i.scale_lo == cfg_i.scale_hi) &&
                  (cfg_i.scale_lo != ZERO_OUT)));
    hold_bad  = cfg_i.hold_code > HOLD_MAX;
    mode_bad  = ((cfg_i.conv_mode != MODE_A) && (cfg_i.conv_mode != MODE_B)) ||
                ((cfg_i.op_mode != MODE_A) && (cfg_i.op_mode != MODE_B));
  end

  // Control state: restart sequencing, sticky setup and storage flags, lamp flash
  ouas_state_t state, next_state;
  logic [23:0] rst_cnt, next_rst_cnt;
  logic [23:0] flash_cnt, next_flash_cnt;
  logic        flash, next_flash;
  logic        scale_f, hold_f, mode_f;
  logic        next_scale_f, next_hold_f, next_mode_f;
  logic        nvf, next_nvf;
  logic        nvf_armed, next_nvf_armed;
  logic        commit_d, next_commit_d;
  logic        setup_any;

  always_comb begin
    next_state     = state;
    next_rst_cnt   = rst_cnt;
    next_scale_f   = scale_f;
    next_hold_f    = hold_f;
    next_mode_f    = mode_f;
    next_nvf       = nvf;
    next_nvf_armed = nvf_armed;
    next_commit_d  = commit;
    next_flash     = 1'b0;
    next_flash_cnt = 24'h000000;
    case (state)
      ST_RESTART: begin
        // Setup flags cleared only here
        next_scale_f = 1'b0;
        next_hold_f  = 1'b0;
        next_mode_f  = 1'b0;
        if (rst_cnt >= 24'(RESTART_CYC - 1))
          next_state = ST_RUN;
        else
          next_rst_cnt = 24'(rst_cnt + 24'h000001);
      end
      ST_RUN: begin
        next_scale_f = scale_f | scale_bad;
        next_hold_f  = hold_f | hold_bad;
        next_mode_f  = mode_f | mode_bad;
      end
      default: next_state = ST_RESTART;
    endcase
    if (restart_i) begin
      next_state   = ST_RESTART;
      next_rst_cnt = 24'h000000;
    end
    // Storage failure recovery: a commit rise then fall clears; a new failure wins
    if (nvf && commit && !commit_d)
      next_nvf_armed = 1'b1;
    if (nvf_armed && !commit && commit_d) begin
      next_nvf       = 1'b0;
      next_nvf_armed = 1'b0;
    end
    if (cal_q && nv_fail_i) begin
      next_nvf       = 1'b1;
      next_nvf_armed = 1'b0;
    end
    if (cal_q) begin
      next_flash     = flash;
      next_flash_cnt = 24'(flash_cnt + 24'h000001);
      if (flash_cnt >= 24'(FLASH_HALF_CYC - 1)) begin
        next_flash     = !flash;
        next_flash_cnt = 24'h000000;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state     <= ST_RESTART;
      rst_cnt   <= 24'h000000;
      flash_cnt <= 24'h000000;
      flash     <= 1'b0;
      scale_f   <= 1'b0;
      hold_f    <= 1'b0;
      mode_f    <= 1'b0;
      nvf       <= 1'b0;
      nvf_armed <= 1'b0;
      commit_d  <= 1'b0;
    end else begin
      state     <= next_state;
      rst_cnt   <= next_rst_cnt;
      flash_cnt <= next_flash_cnt;
      flash     <= next_flash;
      scale_f   <= next_scale_f;
      hold_f    <= next_hold_f;
      mode_f    <= next_mode_f;
      nvf       <= next_nvf;
      nvf_armed <= next_nvf_armed;
      commit_d  <= next_commit_d;
    end
  end

  // Unit-wide drive mode, in falling priority
  ouas_omode_t omode;
  logic        restarting;

  always_comb begin
    setup_any  = scale_f | hold_f | mode_f;
    restarting = (state == ST_RESTART);
    if (restarting)
      omode = OM_ZERO;
    else if (unit_bad)
      omode = OM_ZERO;
    else if (cal_q) begin
      if (host_mode_err || chsel_err)
        omode = OM_ZERO;
      else
        omode = OM_FREEZE;
    end else if (host_i.host_timeout)
      omode = OM_FREEZE;
    else if (host_i.bus_err || host_i.host_wdt)
      omode = OM_HOLD;
    else if (setup_any)
      omode = OM_HOLD;
    else
      omode = OM_SET;
  end

  // Channels; those beyond NUM_CH report no error and drive zero
  logic [NCH_MAX-1:0] sv_err;
  ouas_outs_t         ch_out;

  for (genvar g = 0; g < NCH_MAX; g++) begin : g_ch
    if (g < NUM_CH) begin : g_used
      ouas_chan u_chan (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .omode_i     (omode),
        .set_val_i   (io_words[OFS_SV0[3:0] + g]),
        .hold_code_i (cfg_i.hold_code),
        .ch_en_i     (cfg_i.ch_en[g]),
        .conv_en_i   (io_words[OFS_CTRL[3:0]][g]),
        .sv_err_o    (sv_err[g]),
        .out_o       (ch_out[g])
      );
    end else begin : g_unused
      assign sv_err[g] = 1'b0;
      assign ch_out[g] = ZERO_OUT;
    end
  end

  // Status word, lamps and read answer
  logic [15:0] status, next_status;
  logic        next_run, next_ualarm, next_hfault;
  logic [15:0] next_rdata;

  always_comb begin
    next_status = STATUS_RST;
    if (host_mode_err)
      next_status[B_CALMODE] = 1'b1;
    else begin
      if (!cal_q)
        next_status[B_SV_LO +: NCH_MAX] = sv_err & {NCH_MAX{!restarting}};
      next_status[B_SCALE]   = scale_f;
      next_status[B_HOLD]    = hold_f;
      next_status[B_MODE]    = mode_f;
      next_status[B_CHSEL]   = chsel_err;
      next_status[B_NVFAIL]  = nvf;
      next_status[B_CALMODE] = cal_q;
    end
    // Bit 15 alone is the mode indicator, not an alarm
    next_ualarm = (|next_status[B_CALMODE-1:0]) || host_mode_err;
    next_run    = !restarting && !setup_any && !unit_bad;
    next_hfault = host_i.bus_err || host_i.host_wdt || host_i.host_timeout ||
                  unit_bad || host_i.io_mismatch;
    next_rdata  = (bus_rd_i && (ofs == OFS_STATUS)) ? status : WORD_RST;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status             <= STATUS_RST;
      bus_rdata_o        <= WORD_RST;
      bus_rvalid_o       <= 1'b0;
      chan_out_o         <= '{default: ZERO_OUT};
      run_lamp_o         <= 1'b0;
      unit_alarm_lamp_o  <= 1'b0;
      host_fault_lamp_o  <= 1'b0;
      calibration_lamp_o <= 1'b0;
    end else begin
      status             <= next_status;
      bus_rdata_o        <= next_rdata;
      bus_rvalid_o       <= bus_rd_i;
      chan_out_o         <= ch_out;
      run_lamp_o         <= next_run;
      unit_alarm_lamp_o  <= next_ualarm;
      host_fault_lamp_o  <= next_hfault;
      calibration_lamp_o <= flash;
    end
  end
endmodule // ouas_top

// >>> pkg/ouas_pkg.sv
// Constants, carriers and state types of the output unit alarm/status block.
// Assumes a 10 MHz module clock and a host that refreshes words of the shared I/O area.
package ouas_pkg;

  localparam int          NCH_MAX       = 8;
  localparam int          IO_WORDS      = 9;

  // Shared I/O area addressing (word addresses)
  localparam logic [15:0] IO_BASE       = 16'h07D0;
  localparam logic [15:0] IO_STRIDE     = 16'h000A;
  localparam logic [15:0] OFS_CTRL      = 16'h0000;
  localparam logic [15:0] OFS_CAL_CTRL  = 16'h0001;
  localparam logic [15:0] OFS_SV0       = 16'h0001;
  localparam logic [15:0] OFS_STATUS    = 16'h0009;
  localparam logic [6:0]  UNIT_MAX      = 7'h5F;

  // Status word and calibration control word field positions
  localparam int          B_SV_LO       = 0;
  localparam int          B_SCALE       = 8;
  localparam int          B_HOLD        = 10;
  localparam int          B_MODE        = 12;
  localparam int          B_CHSEL       = 13;
  localparam int          B_NVFAIL      = 14;
  localparam int          B_CALMODE     = 15;
  localparam int          B_COMMIT      = 4;
  localparam logic [15:0] STATUS_RST    = 16'h0000;
  localparam logic [15:0] WORD_RST      = 16'h0000;

  // Value ranges
  localparam logic [15:0] SV_MIN        = 16'hFF38;
  localparam logic [15:0] SV_MAX        = 16'h1068;
  localparam logic [15:0] FULL_SCALE    = 16'h0FA0;
  localparam logic [15:0] ZERO_OUT      = 16'h0000;
  localparam logic [15:0] SCALE_MIN     = 16'h8300;
  localparam logic [15:0] SCALE_MAX     = 16'h7D00;
  localparam logic [15:0] HOLD_CLR      = 16'h0000;
  localparam logic [15:0] HOLD_LAST     = 16'h0001;
  localparam logic [15:0] HOLD_MAX      = 16'h0002;
  localparam logic [7:0]  MODE_A        = 8'h00;
  localparam logic [7:0]  MODE_B        = 8'h01;
  localparam logic [7:0]  CAL_SEL_LO    = 8'h11;
  localparam logic [7:0]  CAL_SEL_HI    = 8'h14;

  // Timing
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          FLASH_HALF_MS = 250;
  localparam int          FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int          RESTART_MS    = 1;
  localparam int          RESTART_CYC   = RESTART_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic        scale_en;
    logic [15:0] scale_lo;
    logic [15:0] scale_hi;
    logic [15:0] hold_code;
    logic [7:0]  conv_mode;
    logic [7:0]  op_mode;
    logic [7:0]  ch_en;
  } ouas_cfg_t;

  typedef struct packed {
    logic bus_err;
    logic host_wdt;
    logic host_timeout;
    logic unit_dup;
    logic io_mismatch;
    logic host_run_mode;
  } ouas_host_t;

  typedef logic [NCH_MAX-1:0][15:0] ouas_outs_t;

  typedef enum logic [1:0] {OM_ZERO, OM_FREEZE, OM_HOLD, OM_SET} ouas_omode_t;
  typedef enum logic [0:0] {ST_RESTART, ST_RUN} ouas_state_t;

endpackage

// >>> core/ouas_chan.sv
// One analogue output channel: range check of the set value and output drive selection.
// Assumes the parent supplies a drive mode already resolved from unit-wide faults.
`timescale 1ns/10ps
module ouas_chan (
  input  wire logic               clock_i,
  input  wire logic               srst_i,
  input  wire ouas_pkg::ouas_omode_t omode_i,
  input  wire logic [15:0]        set_val_i,
  input  wire logic [15:0]        hold_code_i,
  input  wire logic               ch_en_i,
  input  wire logic               conv_en_i,
  output logic                    sv_err_o,
  output logic [15:0]             out_o
);
  import ouas_pkg::*;

  logic [15:0] next_out;
  logic [15:0] hold_val;

  // Signed window check; clears itself once the host writes a legal value
  always_comb begin
    sv_err_o = ($signed(set_val_i) < $signed(SV_MIN)) ||
               ($signed(set_val_i) > $signed(SV_MAX));
  end

  always_comb begin
    case (hold_code_i)
      HOLD_CLR:  hold_val = ZERO_OUT;
      HOLD_LAST: hold_val = out_o;
      HOLD_MAX:  hold_val = FULL_SCALE;
      default:   hold_val = ZERO_OUT;
    endcase
  end

  always_comb begin
    case (omode_i)
      OM_ZERO:   next_out = ZERO_OUT;
      OM_FREEZE: next_out = out_o;
      OM_HOLD:   next_out = hold_val;
      OM_SET: begin
        if (!ch_en_i)
          next_out = ZERO_OUT;
        else if (!conv_en_i || sv_err_o)
          next_out = hold_val;
        else
          next_out = set_val_i;
      end
      default:   next_out = ZERO_OUT;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i)
      out_o <= ZERO_OUT;
    else
      out_o <= next_out;
  end
endmodule // ouas_chan

// >>> tb/ouas_asserts.sv
// Checker for the output unit alarm block: lamps, status word answers and drive.
// Assumes it is bound onto ouas_top and sees only that module's ports.
`timescale 1ns/10ps
module ouas_asserts #(
  parameter int NUM_CH         = 8,
  parameter int FLASH_HALF_CYC = 8,
  parameter int RESTART_CYC    = 4
) (
  input wire logic                 clock_i,
  input wire logic                 srst_i,
  input wire logic [6:0]           unit_no_i,
  input wire logic                 cal_sw_i,
  input wire ouas_pkg::ouas_host_t host_i,
  input wire logic                 restart_i,
  input wire logic                 bus_rd_i,
  input wire logic [15:0]          bus_rdata_o,
  input wire logic                 bus_rvalid_o,
  input wire ouas_pkg::ouas_outs_t chan_out_o,
  input wire logic                 run_lamp_o,
  input wire logic                 unit_alarm_lamp_o,
  input wire logic                 host_fault_lamp_o,
  input wire logic                 calibration_lamp_o
);
  import ouas_pkg::*;
  logic [3:0] hi_n;
  logic [3:0] lo_n;
  logic [3:0] bad_n;
  logic [7:0] stay_n;
  logic       lamp_q;
  // Saturating counters give the pin synchronisers time to settle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hi_n   <= '0;
      lo_n   <= '0;
      bad_n  <= '0;
      stay_n <= '0;
      lamp_q <= 1'b0;
    end else begin
      hi_n   <= !cal_sw_i ? 4'h0 : hi_n + 4'(hi_n != 4'hF);
      lo_n   <= cal_sw_i ? 4'h0 : lo_n + 4'(lo_n != 4'hF);
      bad_n  <= (unit_no_i <= UNIT_MAX) ? 4'h0 : bad_n + 4'(bad_n != 4'hF);
      lamp_q <= calibration_lamp_o;
      stay_n <= (calibration_lamp_o != lamp_q || hi_n != 4'hF) ? 8'h00 :
                stay_n + 8'(stay_n != 8'hFF);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_RESTART_ZERO: assert property (restart_i |-> ##[1:4] (chan_out_o == '0))
    else $error("outputs not zero during restart");
  AST_READ_ANSWER: assert property (bus_rd_i |=> bus_rvalid_o)
    else $error("read not answered next cycle");
  AST_CAL_DARK: assert property (lo_n > 4'h8 |-> !calibration_lamp_o)
    else $error("calibration lamp lit outside calibration");
  AST_CAL_FLASH: assert property (hi_n == 4'hF |-> stay_n <= 8'(FLASH_HALF_CYC))
    else $error("calibration lamp not flashing");
  AST_BIT15_SET: assert property (bus_rvalid_o && hi_n == 4'hF |-> bus_rdata_o[15])
    else $error("calibration flag missing");
  AST_BIT15_CLR: assert property (bus_rvalid_o && lo_n == 4'hF |-> !bus_rdata_o[15])
    else $error("calibration flag set in normal mode");
  AST_UNIT_LAMP: assert property (bus_rvalid_o && bus_rdata_o[14:0] != '0
    |-> ##[0:1] unit_alarm_lamp_o) else $error("unit lamp dark with alarm set");
  AST_HOST_LAMP: assert property ((host_i.bus_err || host_i.host_wdt ||
    host_i.host_timeout || host_i.io_mismatch) |-> ##[1:2] host_fault_lamp_o)
    else $error("host lamp dark on host fault");
  AST_BAD_UNIT: assert property (bad_n == 4'hF |-> host_fault_lamp_o &&
    !run_lamp_o && chan_out_o == '0) else $error("bad unit number not handled");
endmodule // ouas_asserts

bind ouas_top ouas_asserts #(
  .NUM_CH(NUM_CH), .FLASH_HALF_CYC(FLASH_HALF_CYC), .RESTART_CYC(RESTART_CYC)
) chk_u (
  .clock_i(clock_i), .srst_i(srst_i), .unit_no_i(unit_no_i), .cal_sw_i(cal_sw_i),
  .host_i(host_i), .restart_i(restart_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o), .chan_out_o(chan_out_o),
  .run_lamp_o(run_lamp_o), .unit_alarm_lamp_o(unit_alarm_lamp_o),
  .host_fault_lamp_o(host_fault_lamp_o), .calibration_lamp_o(calibration_lamp_o)
);

// >>> tb/ouas_host_bfm.sv
// Host side model: refreshes shared I/O words with one-cycle strobes.
// Assumes the testbench calls its tasks from a process on the same clock.
`timescale 1ns/10ps
module ouas_host_bfm (
  input  wire logic   clock_i,
  output logic        bus_wr_o,
  output logic        bus_rd_o,
  output logic [15:0] bus_addr_o,
  output logic [15:0] bus_wdata_o
);
  import ouas_pkg::*;
  initial begin
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
    bus_addr_o  = 16'h0000;
    bus_wdata_o = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus_wr_o    <= wr;
    bus_rd_o    <= !wr;
    bus_addr_o  <= a;
    bus_wdata_o <= d;
    @(posedge clock_i);
    // Idle lines carry junk so a stale word is never mistaken for a fresh one
    bus_wr_o    <= 1'b0;
    bus_rd_o    <= 1'b0;
    bus_addr_o  <= ~a;
    bus_wdata_o <= ~d;
  endtask
  task automatic commit(input logic [15:0] a);
    xfer(1'b1, a, 16'h0000);
    xfer(1'b1, a, 16'(1) << B_COMMIT);
    xfer(1'b1, a, 16'h0000);
  endtask
endmodule // ouas_host_bfm

// >>> tb/tb.sv
// Self-checking bench of the output unit alarm block, four-channel variant.
// Assumes the host model drives the bus; status answers checked from a queue.
`timescale 1ns/10ps
module tb;
  import ouas_pkg::*;
  localparam logic [15:0] BASE = IO_BASE + 16'h0003 * IO_STRIDE;
  localparam logic [15:0] ST   = BASE + OFS_STATUS;
  logic        clk, srst, cal_sw, restart, nv_fail, wr, rd, rvalid, l;
  logic        run_l, unit_l, host_l, cal_l;
  logic [6:0]  unit_no;
  logic [15:0] addr, wdata, rdata, v, e;
  ouas_host_t  host;
  ouas_cfg_t   cfg, good, c;
  ouas_outs_t  outs;
  logic [15:0] expq[$];
  int          hb[5] = '{5, 4, 2, 1, 3};
  int          err_count, tests_run;
  ouas_top #(.NUM_CH(4), .FLASH_HALF_CYC(8), .RESTART_CYC(4)) dut_u (
    .clock_i(clk), .srst_i(srst), .unit_no_i(unit_no), .cal_sw_i(cal_sw), .host_i(host),
    .cfg_i(cfg), .restart_i(restart), .nv_fail_i(nv_fail), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
    .chan_out_o(outs), .run_lamp_o(run_l), .unit_alarm_lamp_o(unit_l),
    .host_fault_lamp_o(host_l), .calibration_lamp_o(cal_l));
  ouas_host_bfm host_u (.clock_i(clk), .bus_wr_o(wr), .bus_rd_o(rd), .bus_addr_o(addr),
    .bus_wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_st(input logic [15:0] x);
    expq.push_back(x);
    host_u.xfer(1'b0, ST, 16'h0000);
    tick(2);
  endtask
  // Read answers stand one cycle; the watcher looks mid-cycle
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() > 0) chk(rdata, expq.pop_front());
      else chk(rdata, ~rdata);
    end
  end
  initial begin
    #2_000_000;
    err_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'hB614));
    good = '0;
    good.hold_code = HOLD_MAX;
    good.op_mode = MODE_B;
    good.ch_en = 8'h0F;
    cfg = good;
    host = '0;
    unit_no = 7'h03;
    {cal_sw, restart, nv_fail} = 3'b000;
    srst = 1'b1;
    tick(6);
    srst <= 1'b0;
    tick(12);
    chk(16'(run_l), 16'h0001);
    chk(16'(cal_l), 16'h0000);
    rd_st(16'h0000);
    // Never zero, so a frozen live value differs from a zeroed output
    v = 16'($urandom_range(32'h1068, 32'h0001));
    host_u.xfer(1'b1, BASE + OFS_CTRL, 16'h000F);
    host_u.xfer(1'b1, BASE + OFS_SV0, v);
    host_u.xfer(1'b1, BASE + 16'h0002, 16'h1069);
    host_u.xfer(1'b1, BASE + 16'h0006, 16'h2000);
    tick(4);
    chk(outs[0], v);
    chk(outs[1], FULL_SCALE);
    chk(16'(unit_l), 16'h0001);
    rd_st(16'h0002);
    host_u.xfer(1'b1, BASE + 16'h0002, SV_MIN);
    tick(4);
    chk(outs[1], SV_MIN);
    rd_st(16'h0000);
    for (int i = 0; i < 3; i++) begin
      c = good;
      case (i)
        0: {c.scale_en, c.scale_lo, c.scale_hi} = {1'b1, 16'h0100, 16'h0100};
        1: c.hold_code = 16'h0003;
        default: c.op_mode = 8'h02;
      endcase
      e = 16'(1) << (i == 0 ? B_SCALE : (i == 1 ? B_HOLD : B_MODE));
      cfg <= c;
      tick(4);
      rd_st(e);
      chk(16'(run_l), 16'h0000);
      cfg <= good;
      tick(4);
      rd_st(e);
      restart <= 1'b1;
      tick(1);
      restart <= 1'b0;
      tick(12);
      rd_st(16'h0000);
      chk(16'(run_l), 16'h0001);
    end
    host_u.xfer(1'b1, BASE + OFS_CTRL, 16'h000F);
    host_u.xfer(1'b1, BASE + OFS_SV0, v);
    tick(4);
    foreach (hb[k]) begin
      e = (hb[k] >= 4) ? FULL_SCALE : ((hb[k] == 2) ? ZERO_OUT : v);
      host <= ouas_host_t'(6'h01 << hb[k]);
      tick(4);
      // Freeze is only visible if the set value moves underneath it
      if (hb[k] == 3) host_u.xfer(1'b1, BASE + OFS_SV0, ~v & 16'h0FFF);
      tick(4);
      chk(16'(host_l), 16'h0001);
      chk(outs[0], e);
      host <= '0;
      tick(4);
    end
    unit_no <= 7'h60;
    tick(20);
    chk({host_l, run_l, outs[0][13:0]}, 16'h8000);
    unit_no <= 7'h03;
    tick(12);
    expq.push_back(16'h0000);
    host_u.xfer(1'b0, BASE + 16'h000A, 16'h0000);
    tick(2);
    // Select a valid channel first, so calibration freezes a live output
    host_u.xfer(1'b1, BASE + OFS_CTRL, {8'h00, CAL_SEL_LO});
    host_u.xfer(1'b1, BASE + OFS_SV0, v);
    tick(4);
    chk(outs[0], v);
    cal_sw <= 1'b1;
    tick(16);
    rd_st(16'h8000);
    l = cal_l;
    tick(8);
    chk(16'(cal_l), 16'(!l));
    nv_fail <= 1'b1;
    tick(1);
    nv_fail <= 1'b0;
    tick(4);
    rd_st(16'hC000);
    chk(outs[0], v);
    host_u.commit(BASE + OFS_CAL_CTRL);
    tick(4);
    rd_st(16'h8000);
    host <= ouas_host_t'(6'h01);
    tick(6);
    rd_st(16'h8000);
    chk(outs[0], ZERO_OUT);
    chk(16'(unit_l), 16'h0001);
    host <= '0;
    cal_sw <= 1'b0;
    tick(16);
    rd_st(16'h0000);
    // Commit sequence overwrote the set value; restore it before re-entering
    host_u.xfer(1'b1, BASE + OFS_SV0, v);
    tick(4);
    chk(outs[0], v);
    cal_sw <= 1'b1;
    tick(16);
    host_u.xfer(1'b1, BASE + OFS_CTRL, 16'h0015);
    tick(4);
    rd_st(16'hA000);
    chk(outs[0], ZERO_OUT);
    host_u.xfer(1'b1, BASE + OFS_CTRL, {8'h00, CAL_SEL_LO});
    c = good;
    c.ch_en = 8'h0E;
    cfg <= c;
    tick(4);
    rd_st(16'hA000);
    cfg <= good;
    tick(4);
    rd_st(16'h8000);
    cal_sw <= 1'b0;
    tick(16);
    rd_st(16'h0000);
    chk(16'(cal_l), 16'h0000);
    chk(16'(expq.size()), 16'h0000);
    test_done();
  end
endmodule // tb
